// file: bench/fesc_flash_model.sv
// behavioural nor flash: erase sequences, window, suspend, status reads
// assumes the sequencer's flash pins with matching names
`timescale 1ns/100ps
module fesc_flash_model #(
  parameter int WIN_NS = 1600,
  parameter int ERASE_READS = 3
) (
  // flash pins
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  output logic [15:0] flash_dq_in
);
  logic [2:0] mode = 0; // 0 read 1 chip 2 window 3 erasing 4 suspended
  logic [2:0] seq = 0;
  logic [127:0] sel = 0;
  logic [15:0] last = 0;
  logic tg = 0;
  int left = 0;
  realtime t_last = 0;
  wire [7:0] d = flash_dq_out[7:0];
  wire [10:0] a = flash_addr[10:0];
  wire unl = (seq == 0 || seq == 3) ? (d == 8'hAA && a == 11'h555) :
             (seq == 1 || seq == 4) ? (d == 8'h55 && a == 11'h2AA) : (d == 8'h80 && a == 11'h555);
  // command decode on the rising write strobe
  always @(posedge flash_we_n or negedge flash_reset_n) begin
    if (!flash_reset_n) begin
      mode = 0;
      seq = 0;
    end else if (!flash_ce_n) begin
      if (mode == 2 && $realtime - t_last >= WIN_NS) mode = 3;
      case (mode)
        0: if (seq == 5) begin
          seq = 0;
          left = ERASE_READS;
          if (d == 8'h10 && a == 11'h555) mode = 1;
          else if (d == 8'h30) begin
            mode = 2;
            sel = 0;
            sel[flash_addr[21:15]] = 1;
            t_last = $realtime;
          end
        end else seq = unl ? seq + 1 : 0;
        2: if (d == 8'h30) begin
          sel[flash_addr[21:15]] = 1;
          t_last = $realtime;
        end else if (d == 8'hB0) mode = 4;
        else mode = 0;
        3: if (d == 8'hB0) mode = 4;
        4: if (d == 8'h30) mode = 3;
        default: ; // chip erase ignores all
      endcase
    end
  end
  // read: status while erasing or in the window, or from a selected sector while suspended, array pattern otherwise
  always @(negedge flash_oe_n) begin
    if (mode == 2 && $realtime - t_last >= WIN_NS) mode = 3;
    if (mode == 1 || mode == 3) begin
      if (left == 0) mode = 0;
      else left--;
    end
    tg = ~tg;
    if (mode == 0 || (mode == 4 && !sel[flash_addr[21:15]])) last = ~flash_addr[15:0];
    else if (mode == 4) last = {8'h00, 1'b1, 3'h0, 1'b1, tg, 2'h0};
    else last = {8'h00, 1'b0, tg, 2'h0, mode != 2, tg, 2'h0};
  end
  // a released bus never shows the last value
  assign flash_dq_in = (!flash_oe_n && !flash_ce_n) ? last : ~last;
endmodule

// file: bench/fesc_top_sva.sv
// flash pin and axi answer checks for the sequencer
// assumes binding to fesc_top
`timescale 1ns/100ps
module fesc_top_sva #(
  parameter int RST_CYC = 63
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int rcnt; // cycles of hardware reset pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst || flash_reset_n) rcnt <= 0;
    else rcnt <= rcnt + 1;
  end
  sequence s_strobe;
    !flash_we_n [*6] ##1 flash_we_n;
  endsequence
  sequence s_tail;
    !flash_ce_n ##1 !flash_ce_n ##1 flash_ce_n;
  endsequence
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> s_strobe)
    else $error("write strobe width wrong");
  AST_CE_LEAD: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n, 2) && flash_dq_oe)
    else $error("chip select lead wrong");
  AST_CE_TAIL: assert property ($rose(flash_we_n) |-> s_tail)
    else $error("chip select tail wrong");
  AST_ADDR_HOLD: assert property (!flash_ce_n && !$past(flash_ce_n) |->
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address moved in cycle");
  AST_NO_CLASH: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("read overlaps drive");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_RST_LEN: assert property ($rose(flash_reset_n) |-> rcnt == RST_CYC)
    else $error("reset pulse length wrong");
  AST_WE_IN_CE: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("strobe outside select");
endmodule
bind fesc_top fesc_top_sva #(.RST_CYC(RST_CYC)) u_fesc_top_sva (.*);

// file: bench/fesc_top_tb.sv
// self-checking bench: axi4-lite jobs against the flash model
// assumes short window, settle and reset counts
`timescale 1ns/100ps
module fesc_top_tb;
  import fesc_pkg::*;
  logic core_clk = 0, sys_rst = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, s;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int n_mismatch = 0, tests_run = 0;
  time t0;
  fesc_top #(.WIN_CYC(200), .SUSP_CYC(20), .RST_CYC(4)) u_fesc_top (.*);
  fesc_flash_model #(.WIN_NS(1600)) u_fesc_flash_model (.*);
  initial forever #4 core_clk = ~core_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ao, wo, bo;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(negedge core_clk);
      ao = s_axi_awready;
      wo = s_axi_wready;
      bo = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ao) s_axi_awvalid <= 0;
      if (wo) s_axi_wvalid <= 0;
    end while (!bo);
    // answer kept waiting one edge so the slave has to hold it
    s_axi_bready <= 1;
    @(posedge core_clk);
    s_axi_bready <= 0;
    chk(32'(r), 32'(e));
  endtask
  task rd(input logic [3:0] a, input logic [1:0] e);
    logic ao, bo;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(negedge core_clk);
      ao = s_axi_arready;
      bo = s_axi_rvalid;
      s = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ao) s_axi_arvalid <= 0;
    end while (!bo);
    s_axi_rready <= 1;
    @(posedge core_clk);
    s_axi_rready <= 0;
    chk(32'(r), 32'(e));
  endtask
  task job(input logic [2:0] j, input logic [1:0] e);
    wr(4'h0, {29'h0, j}, e);
    do rd(4'hC, 2'h0); while (s[0] !== 1'b0);
  endtask
  task md(input logic [2:0] m);
    rd(4'hC, 2'h0);
    chk(32'(s[4:2]), 32'(m));
  endtask
  task done;
    do begin
      job(3'h7, 2'h0);
      rd(4'hC, 2'h0);
    end while (s[4:2] !== 3'h0);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    md(3'h0);
    rd(4'h2, 2'h2);
    chk(s, 32'h0);
    job(3'h4, 2'h2);
    job(3'h5, 2'h2);
    $display("test refusals done");
    job(3'h1, 2'h0);
    md(3'h1);
    chk(32'(u_fesc_flash_model.mode), 32'h1);
    job(3'h4, 2'h2);
    job(3'h2, 2'h2);
    done();
    chk(32'(u_fesc_flash_model.mode), 32'h0);
    wr(4'h8, 32'h1234, 2'h0);
    job(3'h6, 2'h0);
    rd(4'hC, 2'h0);
    chk(32'(s[31:16]), 32'hEDCB);
    $display("test chip erase done");
    wr(4'h4, 32'h5A, 2'h0);
    job(3'h2, 2'h0);
    md(3'h2);
    chk(32'(s[8]), 32'h1);
    wr(4'h4, 32'h3, 2'h0);
    job(3'h3, 2'h0);
    chk(32'(u_fesc_flash_model.sel[3]), 32'h1);
    job(3'h4, 2'h0);
    md(3'h4);
    wr(4'h8, 32'h2D0000, 2'h0);
    job(3'h6, 2'h0);
    rd(4'hC, 2'h0);
    chk(32'(s[23]), 32'h1);
    job(3'h5, 2'h0);
    md(3'h3);
    job(3'h5, 2'h2);
    t0 = $time;
    job(3'h4, 2'h0);
    chk(32'($time - t0 >= 280), 32'h1);
    md(3'h4);
    job(3'h5, 2'h0);
    done();
    $display("test suspend done");
    job(3'h2, 2'h0);
    repeat (210) @(posedge core_clk);
    md(3'h3);
    chk(32'(s[8]), 32'h0);
    job(3'h3, 2'h2);
    job(3'h0, 2'h0);
    md(3'h0);
    chk(32'(u_fesc_flash_model.mode), 32'h0);
    $display("test timeout and reset done");
    final_report;
  end
endmodule

// file: src/fesc_bus_cycle.sv
// one asynchronous flash bus cycle (write, read) or a hardware reset pulse
// assumes the flash data pins are resolved outside from dq_out and dq_oe
`timescale 1ns/100ps
`include "fesc_map.svh"
module fesc_bus_cycle
  import fesc_pkg::*;
#(
  parameter int RST_CYC = 63
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request side
  input wire logic start,
  input wire logic wr,
  input wire logic hw_rst,
  input wire logic [21:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // flash pins
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n
);
  fesc_bc_t state; // cycle phase
  logic [7:0] cnt; // cycles left in phase
  logic is_wr; // latched direction

  // ----------------------------------------------------------------
  // phase sequencing and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= FESC_BC_IDLE;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 22'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_reset_n <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (state)
        FESC_BC_IDLE: begin
          if (hw_rst) begin
            // reset pin low: ends any erase at once
            flash_reset_n <= 1'b0;
            cnt <= RST_CYC[7:0];
            state <= FESC_BC_RESET;
          end else if (start) begin
            // address and ce first, strobe after setup
            is_wr <= wr;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= wr;
            flash_ce_n <= 1'b0;
            cnt <= `FESC_SETUP_CYC;
            state <= FESC_BC_SETUP;
          end
        end
        FESC_BC_SETUP: begin
          if (cnt == 8'h01) begin
            flash_we_n <= ~is_wr;
            flash_oe_n <= is_wr;
            cnt <= is_wr ? `FESC_STROBE_CYC : `FESC_READ_CYC;
            state <= FESC_BC_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FESC_BC_STROBE: begin
          if (cnt == 8'h01) begin
            // rising we edge latches data; read samples before oe rises
            if (!is_wr) begin
              rdata <= flash_dq_in;
            end
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt <= `FESC_HOLD_CYC;
            state <= FESC_BC_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FESC_BC_HOLD: begin
          if (cnt == 8'h01) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= FESC_BC_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FESC_BC_RESET: begin
          if (cnt == 8'h01) begin
            flash_reset_n <= 1'b1;
            done <= 1'b1;
            state <= FESC_BC_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// file: src/fesc_map.svh
// register map, command codes and timing figures of the erase/suspend sequencer
// assumes inclusion by bare name from the package and the design modules
`ifndef FESC_MAP_SVH
`define FESC_MAP_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define FESC_OFF_CTRL 4'h0
`define FESC_OFF_SECTOR 4'h4
`define FESC_OFF_RADDR 4'h8
`define FESC_OFF_STATUS 4'hC
// ----------------------------------------------------------------
// control register job codes (bits 2:0)
// ----------------------------------------------------------------
`define FESC_JOB_CHIP 3'h1
`define FESC_JOB_SECT 3'h2
`define FESC_JOB_ADD 3'h3
`define FESC_JOB_SUSP 3'h4
`define FESC_JOB_RESUME 3'h5
`define FESC_JOB_READ 3'h6
`define FESC_JOB_POLL 3'h7
`define FESC_JOB_HWRST 3'h0
// ----------------------------------------------------------------
// flash command words (word mode)
// ----------------------------------------------------------------
`define FESC_ADR_UNLK1 22'h000555
`define FESC_ADR_UNLK2 22'h0002AA
`define FESC_DAT_UNLK1 16'h00AA
`define FESC_DAT_UNLK2 16'h0055
`define FESC_DAT_SETUP 16'h0080
`define FESC_DAT_CHIP 16'h0010
`define FESC_DAT_SECT 16'h0030
`define FESC_DAT_RESUME 16'h0030
`define FESC_DAT_SUSP 16'h00B0
`define FESC_SECT_LSB 15
`define FESC_SEQ_LAST 3'h5
// ----------------------------------------------------------------
// status bit positions in the low data byte
// ----------------------------------------------------------------
`define FESC_BIT_TOGGLE 6
`define FESC_BIT_ETOGGLE 2
`define FESC_BIT_TIMER 3
// ----------------------------------------------------------------
// timing (clock in MHz, times in their own units)
// ----------------------------------------------------------------
`define FESC_CLK_MHZ 125
`define FESC_WIN_US 50
`define FESC_SUSP_US 20
`define FESC_RST_NS 500
`define FESC_SETUP_CYC 8'h02
`define FESC_STROBE_CYC 8'h06
`define FESC_READ_CYC 8'h0C
`define FESC_HOLD_CYC 8'h02
// cycles from a rising write strobe until the sequencer sees the cycle done
`define FESC_WIN_LAG 32'h00000003
// cycles from taking an add job until its own strobe rises, plus one
`define FESC_WIN_LEAD 32'h0000000B
`endif

// file: src/fesc_pkg.sv
// types shared by the erase/suspend sequencer modules
// assumes the map header sits beside it
`include "fesc_map.svh"
package fesc_pkg;
  // host's view of what the flash is doing
  typedef enum logic [2:0] {
    FESC_M_READ,
    FESC_M_CHIP,
    FESC_M_WIN,
    FESC_M_SERASE,
    FESC_M_SUSP
  } fesc_mode_t;
  // flash bus cycle engine states
  typedef enum logic [2:0] {
    FESC_BC_IDLE,
    FESC_BC_SETUP,
    FESC_BC_STROBE,
    FESC_BC_HOLD,
    FESC_BC_RESET
  } fesc_bc_t;
  // job sequencer states
  typedef enum logic [2:0] {
    FESC_SQ_IDLE,
    FESC_SQ_ISSUE,
    FESC_SQ_WAIT,
    FESC_SQ_SETTLE
  } fesc_sq_t;
endpackage

// file: src/fesc_top.sv
// host-side erase/suspend sequencer for a parallel nor flash, word mode
// assumes an axi4-lite master and a flash wired to the flash_* pins
// Summary of operation
// - resume any address; repeats ignored by flash
// - chip erase: six writes in fixed order
// - sector erase: six writes, last at sector
// - host spaces added sectors under 50 us
// - erase resume; repeats ignored; resuspend later
// - unlock cycles decode only low address bits
// - sector chosen by address bits 21..15
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "fesc_map.svh"
module fesc_top
  import fesc_pkg::*;
#(
  parameter int WIN_CYC = `FESC_WIN_US * `FESC_CLK_MHZ, // longest gap, rounded down
  parameter int SUSP_CYC = `FESC_SUSP_US * `FESC_CLK_MHZ, // least settle, rounded up
  parameter int RST_CYC = (`FESC_RST_NS * `FESC_CLK_MHZ + 999) / 1000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // axi4-lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic aw_held; // write address taken
  logic w_held; // write data taken
  logic [3:0] aw_addr; // held write address
  logic [31:0] w_data; // held write data
  logic [3:0] w_strb; // held byte enables
  logic [6:0] sector; // sector select, address bits 21..15
  logic [21:0] raddr; // address used by read and poll jobs
  logic [15:0] last_read; // last word read from the flash
  logic poll_toggling; // toggle bit moved between the two poll reads
  logic poll_etoggling; // erase toggle bit moved between them
  fesc_mode_t mode; // host's model of the flash
  fesc_sq_t sq; // job sequencer state
  logic [2:0] job; // job under way
  logic [2:0] step; // write index in a six-write sequence
  logic [15:0] first_read; // first poll read
  logic [31:0] win_cnt; // cycles since last sector erase strobe
  logic [31:0] settle_cnt; // suspend settle counter
  logic bc_start; // start one bus cycle
  logic bc_wr; // that cycle is a write
  logic bc_rst; // start a reset pulse
  logic [21:0] bc_addr; // cycle address
  logic [15:0] bc_data; // cycle data
  logic bc_done; // cycle finished
  logic [15:0] bc_rdata; // read data
  logic wr_fire; // both write halves present
  logic job_ok; // job legal in current mode
  logic win_open; // acceptance window still running

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // an add must raise its strobe before the flash closes the window
  assign win_open = (mode == FESC_M_WIN) && (win_cnt + `FESC_WIN_LEAD < WIN_CYC);

  // ----------------------------------------------------------------
  // job legality against the flash's mode
  // ----------------------------------------------------------------
  always_comb begin
    job_ok = 1'b0;
    if (sq == FESC_SQ_IDLE) begin
      unique case (w_data[2:0])
        // chip erase takes only a reset, read or poll; suspend only in sector erase
        `FESC_JOB_HWRST: job_ok = 1'b1;
        `FESC_JOB_CHIP, `FESC_JOB_SECT: job_ok = (mode == FESC_M_READ);
        `FESC_JOB_ADD: job_ok = win_open;
        `FESC_JOB_SUSP: job_ok = (mode == FESC_M_WIN) || (mode == FESC_M_SERASE);
        `FESC_JOB_RESUME: job_ok = (mode == FESC_M_SUSP);
        `FESC_JOB_READ, `FESC_JOB_POLL: job_ok = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word of each write cycle
  // ----------------------------------------------------------------
  always_comb begin
    bc_addr = raddr;
    bc_data = 16'h0000;
    bc_wr = 1'b0;
    unique case (job)
      `FESC_JOB_CHIP, `FESC_JOB_SECT: begin
        bc_wr = 1'b1;
        // unlock, setup, unlock, then the erase word
        unique case (step)
          3'h0, 3'h3: begin
            bc_addr = `FESC_ADR_UNLK1;
            bc_data = `FESC_DAT_UNLK1;
          end
          3'h1, 3'h4: begin
            bc_addr = `FESC_ADR_UNLK2;
            bc_data = `FESC_DAT_UNLK2;
          end
          3'h2: begin
            bc_addr = `FESC_ADR_UNLK1;
            bc_data = `FESC_DAT_SETUP;
          end
          default: begin
            bc_addr = (job == `FESC_JOB_CHIP) ? `FESC_ADR_UNLK1 : {sector, 15'h0000};
            bc_data = (job == `FESC_JOB_CHIP) ? `FESC_DAT_CHIP : `FESC_DAT_SECT;
          end
        endcase
      end
      `FESC_JOB_ADD: begin
        bc_wr = 1'b1;
        bc_addr = {sector, 15'h0000};
        bc_data = `FESC_DAT_SECT;
      end
      `FESC_JOB_SUSP: begin
        bc_wr = 1'b1;
        bc_data = `FESC_DAT_SUSP;
      end
      `FESC_JOB_RESUME: begin
        bc_wr = 1'b1;
        bc_data = `FESC_DAT_RESUME;
      end
      default: bc_wr = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // job sequencer and flash mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sq <= FESC_SQ_IDLE;
      job <= `FESC_JOB_READ;
      step <= 3'h0;
      mode <= FESC_M_READ;
      bc_start <= 1'b0;
      bc_rst <= 1'b0;
      first_read <= 16'h0000;
      last_read <= 16'h0000;
      poll_toggling <= 1'b0;
      poll_etoggling <= 1'b0;
      win_cnt <= 32'h00000000;
      settle_cnt <= 32'h00000000;
    end else begin
      bc_start <= 1'b0;
      bc_rst <= 1'b0;
      // window ages while open; flash starts erasing when it runs out
      if (mode == FESC_M_WIN) begin
        if (win_cnt >= WIN_CYC) begin
          mode <= FESC_M_SERASE;
        end else begin
          win_cnt <= win_cnt + 32'h00000001;
        end
      end
      unique case (sq)
        FESC_SQ_IDLE: begin
          if (wr_fire && aw_addr == `FESC_OFF_CTRL && w_strb[0] && job_ok) begin
            job <= w_data[2:0];
            step <= 3'h0;
            sq <= FESC_SQ_ISSUE;
          end
        end
        FESC_SQ_ISSUE: begin
          bc_start <= (job != `FESC_JOB_HWRST);
          bc_rst <= (job == `FESC_JOB_HWRST);
          sq <= FESC_SQ_WAIT;
        end
        FESC_SQ_WAIT: begin
          if (bc_done) begin
            sq <= FESC_SQ_IDLE;
            unique case (job)
              `FESC_JOB_HWRST: mode <= FESC_M_READ;
              `FESC_JOB_CHIP, `FESC_JOB_SECT: begin
                if (step != `FESC_SEQ_LAST) begin
                  step <= step + 3'h1;
                  sq <= FESC_SQ_ISSUE;
                end else if (job == `FESC_JOB_CHIP) begin
                  mode <= FESC_M_CHIP;
                end else begin
                  // window counts from the rising strobe of the last write
                  mode <= FESC_M_WIN;
                  win_cnt <= `FESC_WIN_LAG;
                end
              end
              `FESC_JOB_ADD: win_cnt <= `FESC_WIN_LAG;
              `FESC_JOB_SUSP: begin
                // in the window the flash suspends at once
                if (mode == FESC_M_WIN) begin
                  mode <= FESC_M_SUSP;
                end else begin
                  settle_cnt <= 32'h00000000;
                  sq <= FESC_SQ_SETTLE;
                end
              end
              `FESC_JOB_RESUME: mode <= FESC_M_SERASE;
              `FESC_JOB_READ: last_read <= bc_rdata;
              default: begin
                // two reads: a steady toggle bit means the erase has finished
                if (step == 3'h0) begin
                  first_read <= bc_rdata;
                  step <= 3'h1;
                  sq <= FESC_SQ_ISSUE;
                end else begin
                  last_read <= bc_rdata;
                  poll_toggling <= first_read[`FESC_BIT_TOGGLE] ^ bc_rdata[`FESC_BIT_TOGGLE];
                  poll_etoggling <= first_read[`FESC_BIT_ETOGGLE] ^ bc_rdata[`FESC_BIT_ETOGGLE];
                  if ((mode == FESC_M_CHIP || mode == FESC_M_SERASE)
                      && first_read[`FESC_BIT_TOGGLE] == bc_rdata[`FESC_BIT_TOGGLE]) begin
                    mode <= FESC_M_READ;
                  end
                end
              end
            endcase
          end
        end
        FESC_SQ_SETTLE: begin
          // flash may take up to the full suspend time to halt
          if (settle_cnt >= SUSP_CYC - 1) begin
            mode <= FESC_M_SUSP;
            sq <= FESC_SQ_IDLE;
          end else begin
            settle_cnt <= settle_cnt + 32'h00000001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path: address and data in either order
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      sector <= 7'h00;
      raddr <= 22'h000000;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        unique case (aw_addr)
          // a job the flash cannot take now is refused with slverr
          `FESC_OFF_CTRL: s_axi_bresp <= job_ok ? 2'h0 : 2'h2;
          `FESC_OFF_SECTOR: begin
            if (w_strb[0]) sector <= w_data[6:0];
          end
          `FESC_OFF_RADDR: begin
            if (w_strb[0]) raddr[7:0] <= w_data[7:0];
            if (w_strb[1]) raddr[15:8] <= w_data[15:8];
            if (w_strb[2]) raddr[21:16] <= w_data[21:16];
          end
          `FESC_OFF_STATUS: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `FESC_OFF_CTRL: s_axi_rdata <= {29'h00000000, job};
          `FESC_OFF_SECTOR: s_axi_rdata <= {25'h0000000, sector};
          `FESC_OFF_RADDR: s_axi_rdata <= {10'h000, raddr};
          `FESC_OFF_STATUS: s_axi_rdata <= {last_read, 7'h00, win_open, poll_etoggling,
                                            poll_toggling, 1'b0, mode, 1'b0,
                                            sq != FESC_SQ_IDLE};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flash bus cycle engine
  // ----------------------------------------------------------------
  fesc_bus_cycle #(
    .RST_CYC(RST_CYC)
  ) u_cycle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(bc_start),
    .wr(bc_wr),
    .hw_rst(bc_rst),
    .addr(bc_addr),
    .wdata(bc_data),
    .done(bc_done),
    .rdata(bc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_reset_n(flash_reset_n)
  );
endmodule
